// File: src/ssp_pkg.sv
// Shared constants and state types for the synchronous serial port pins
package ssp_pkg;

   localparam int                WORD_BITS   = 16;
   localparam int                COUNT_BITS  = 5;
   localparam logic [4:0]        WORD_COUNT  = 5'h10;
   localparam logic [4:0]        COUNT_RESET = 5'h00;
   localparam logic [15:0]       WORD_RESET  = 16'h0000;
   localparam logic              SYNC_RESET  = 1'b0;
   localparam logic              FS_RESET    = 1'b1;

   typedef enum logic [1:0] {
      TX_IDLE,
      TX_SYNC,
      TX_SHIFT
   } tx_phase_type;

   // Everything registered on the master clock
   typedef struct packed {
      tx_phase_type            phase;
      logic                    clk_int;
      logic                    clk_ext_prev;
      logic                    fs_prev;
      logic [WORD_BITS-1:0]    shreg;
      logic [COUNT_BITS-1:0]   count;
      logic                    dx;
      logic                    dx_oe;
      logic                    clk_out;
      logic                    clk_oe;
      logic                    fs_out;
      logic                    fs_oe;
      logic                    underrun;
      logic                    rx_tog_prev;
      logic [WORD_BITS-1:0]    rx_data;
      logic                    rx_valid;
      logic                    clk_level;
   } port_state_type;

   // Everything registered on the receive clock
   typedef struct packed {
      logic                    fs_prev;
      logic                    busy;
      logic [COUNT_BITS-1:0]   count;
      logic [WORD_BITS-1:0]    shreg;
      logic [WORD_BITS-1:0]    hold;
      logic                    toggle;
   } link_state_type;

endpackage

// File: src/sync_bit.sv
// Two flip-flop synchroniser for one level
`timescale 1ns/10ps
`default_nettype none
module sync_bit
   import ssp_pkg::*;
#(
   parameter logic RESET_VALUE = SYNC_RESET
) (
   input  wire logic mclk,
   input  wire logic nrst,
   input  wire logic async_in,
   output var  logic sync_out
);

   logic first;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         first    <= RESET_VALUE;
         sync_out <= RESET_VALUE;
      end else begin
         first    <= async_in;
         sync_out <= first;
      end
   end

endmodule
`default_nettype wire

// File: src/word_buffer.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module word_buffer
   import ssp_pkg::*;
#(
   parameter int WIDTH = WORD_BITS
) (
   input  wire logic             mclk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   output var  logic [WIDTH-1:0] out_data,
   output var  logic             out_valid,
   input  wire logic             out_ready
);

   logic [WIDTH-1:0] mem [2];
   logic             wr_ptr;
   logic             rd_ptr;
   logic [1:0]       count;
   logic             push;
   logic             pop;
   logic [1:0]       next_count;

   assign push     = in_valid && in_ready;
   assign pop      = out_valid && out_ready;
   assign out_data = mem[rd_ptr];

   always_comb begin
      next_count = count;
      if (push && !pop) begin
         next_count = count + 2'h1;
      end else if (pop && !push) begin
         next_count = count - 2'h1;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr    <= 1'b0;
         rd_ptr    <= 1'b0;
         count     <= 2'h0;
         in_ready  <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= !wr_ptr;
         end
         if (pop) begin
            rd_ptr <= !rd_ptr;
         end
         count     <= next_count;
         in_ready  <= (next_count != 2'h2);
         out_valid <= (next_count != 2'h0);
      end
   end

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

endmodule
`default_nettype wire

// File: src/sync_serial_port.sv
// Synchronous serial port pin logic: transmit, receive, clock and frame sync
//
// Summary of operation
// RULE1: With clock source select at 0 the transmit clock pin is an input and its edges time transmit shifting.
// RULE2: With clock source select at 1 the device drives the transmit clock pin at half the master clock.
// RULE3: After reset the transmit clock pin is an input until internal clocking is selected.
// RULE4: Transmit shift register bits leave on the serial transmit pin, most significant first, on transmit clock edges.
// RULE5: The partner keeps the receive clock running throughout every transfer, as no internal receive clock exists.
// RULE6: The current level of the receive clock pin is readable as a status bit.
// RULE7: A falling edge on the receive frame sync starts clocking serial receive bits into the receive shift register.
// RULE8: A falling edge on the transmit frame sync starts shifting the transmit shift register out.
// RULE9: The transmit frame sync is an input after reset and driven by the device when its output select is 1.
// RULE10: Test reset low, emulator pin zero high and the disable pin low float every output driver.
// RULE11: Each frame sync moves exactly one fixed-length word per direction, then the port idles.
`timescale 1ns/10ps
`default_nettype none
module sync_serial_port
   import ssp_pkg::*;
(
   input  wire logic                 mclk,
   input  wire logic                 nrst,
   input  wire logic                 receive_clock_pin,
   input  wire logic                 serial_receive_pin,
   input  wire logic                 receive_frame_sync,
   input  wire logic                 transmit_clock_in,
   output var  logic                 transmit_clock_out,
   output var  logic                 transmit_clock_oe,
   input  wire logic                 transmit_frame_sync_in,
   output var  logic                 transmit_frame_sync_out,
   output var  logic                 transmit_frame_sync_oe,
   output var  logic                 serial_transmit_pin,
   output var  logic                 serial_transmit_oe,
   input  wire logic                 test_reset_pin,
   input  wire logic                 emulator_pin_zero,
   input  wire logic                 emulator_pin_one_disable,
   input  wire logic                 clock_source_select,
   input  wire logic                 frame_sync_output_select,
   input  wire logic [WORD_BITS-1:0] tx_data,
   input  wire logic                 tx_valid,
   output var  logic                 tx_ready,
   output var  logic [WORD_BITS-1:0] rx_data,
   output var  logic                 rx_valid,
   output var  logic                 receive_clock_level_bit,
   output var  logic                 tx_underrun
);

   port_state_type       s;
   port_state_type       next_s;
   link_state_type       r;
   link_state_type       next_r;
   logic                 clk_ext_s;
   logic                 fs_s;
   logic                 trst_s;
   logic                 emulator_pin_zero_s;
   logic                 emu1_s;
   logic                 level_s;
   logic                 rx_tog_s;
   logic                 off_s;
   logic                 tx_rise;
   logic                 fs_fall;
   logic [WORD_BITS-1:0] buf_data;
   logic                 buf_valid;
   logic                 buf_pop;

   // Pin inputs and the receive word toggle into the master clock domain
   sync_bit #(.RESET_VALUE(SYNC_RESET)) u_sync_clk (
      .mclk     (mclk),
      .nrst     (nrst),
      .async_in (transmit_clock_in),
      .sync_out (clk_ext_s)
   );
   sync_bit #(.RESET_VALUE(FS_RESET)) u_sync_fs (
      .mclk     (mclk),
      .nrst     (nrst),
      .async_in (transmit_frame_sync_in),
      .sync_out (fs_s)
   );
   sync_bit #(.RESET_VALUE(SYNC_RESET)) u_sync_trst (
      .mclk     (mclk),
      .nrst     (nrst),
      .async_in (test_reset_pin),
      .sync_out (trst_s)
   );
   sync_bit #(.RESET_VALUE(SYNC_RESET)) u_sync_emulator_pin_zero (
      .mclk     (mclk),
      .nrst     (nrst),
      .async_in (emulator_pin_zero),
      .sync_out (emulator_pin_zero_s)
   );
   sync_bit #(.RESET_VALUE(FS_RESET)) u_sync_emu1 (
      .mclk     (mclk),
      .nrst     (nrst),
      .async_in (emulator_pin_one_disable),
      .sync_out (emu1_s)
   );
   sync_bit #(.RESET_VALUE(SYNC_RESET)) u_sync_level (
      .mclk     (mclk),
      .nrst     (nrst),
      .async_in (receive_clock_pin),
      .sync_out (level_s)
   );
   sync_bit #(.RESET_VALUE(SYNC_RESET)) u_sync_rxtog (
      .mclk     (mclk),
      .nrst     (nrst),
      .async_in (r.toggle),
      .sync_out (rx_tog_s)
   );

   // Transmit words wait here until a frame takes them
   word_buffer #(.WIDTH(WORD_BITS)) u_tx_buffer (
      .mclk      (mclk),
      .nrst      (nrst),
      .in_data   (tx_data),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .out_data  (buf_data),
      .out_valid (buf_valid),
      .out_ready (buf_pop)
   );

   assign off_s   = !trst_s && emulator_pin_zero_s && !emu1_s;                         // [RULE10]
   assign tx_rise = clock_source_select ? !s.clk_int                      // [RULE2]
                                        : (clk_ext_s && !s.clk_ext_prev); // [RULE1]
   assign fs_fall = s.fs_prev && !fs_s;

   // Word load is the only place the buffer is drained
   always_comb begin
      buf_pop = 1'b0;
      if (s.phase == TX_IDLE && !frame_sync_output_select && fs_fall) begin
         buf_pop = buf_valid;
      end else if (s.phase == TX_SYNC && tx_rise) begin
         buf_pop = buf_valid;
      end
   end

   // Master clock domain
   always_comb begin
      next_s              = s;
      next_s.clk_int      = !s.clk_int;
      next_s.clk_ext_prev = clk_ext_s;
      next_s.fs_prev      = fs_s;
      next_s.clk_out      = !s.clk_int;                                   // [RULE2]
      next_s.clk_oe       = clock_source_select && !off_s;                // [RULE1] [RULE3] [RULE10]
      next_s.fs_oe        = frame_sync_output_select && !off_s;           // [RULE9] [RULE10]
      next_s.dx_oe        = !off_s;                                       // [RULE10]
      next_s.underrun     = 1'b0;
      next_s.rx_valid     = 1'b0;
      next_s.rx_tog_prev  = rx_tog_s;
      next_s.clk_level    = level_s;                                      // [RULE6]
      if (rx_tog_s != s.rx_tog_prev) begin
         next_s.rx_data  = r.hold;
         next_s.rx_valid = 1'b1;
      end
      case (s.phase)
         TX_IDLE: begin
            next_s.fs_out = 1'b0;
            if (frame_sync_output_select) begin
               if (tx_rise && buf_valid) begin
                  next_s.fs_out = 1'b1;                                   // [RULE9]
                  next_s.phase  = TX_SYNC;
               end
            end else if (fs_fall) begin
               next_s.phase    = TX_SHIFT;                                // [RULE8]
               next_s.shreg    = buf_valid ? buf_data : WORD_RESET;
               next_s.underrun = !buf_valid;
               next_s.count    = WORD_COUNT;                              // [RULE11]
            end
         end
         TX_SYNC: begin
            if (tx_rise) begin
               next_s.fs_out   = 1'b0;                                    // [RULE8]
               next_s.phase    = TX_SHIFT;
               next_s.shreg    = buf_valid ? buf_data : WORD_RESET;
               next_s.underrun = !buf_valid;
               next_s.count    = WORD_COUNT;                              // [RULE11]
            end
         end
         TX_SHIFT: begin
            if (tx_rise) begin
               next_s.dx    = s.shreg[WORD_BITS-1];                       // [RULE4]
               next_s.shreg = {s.shreg[WORD_BITS-2:0], 1'b0};
               next_s.count = s.count - 5'h01;
               if (s.count == 5'h01) begin
                  next_s.phase = TX_IDLE;                                 // [RULE11]
               end
            end
         end
         default: begin
            next_s.phase = TX_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s.phase        <= TX_IDLE;
         s.clk_int      <= 1'b0;
         s.clk_ext_prev <= 1'b0;
         s.fs_prev      <= FS_RESET;
         s.shreg        <= WORD_RESET;
         s.count        <= COUNT_RESET;
         s.dx           <= 1'b0;
         s.dx_oe        <= 1'b0;
         s.clk_out      <= 1'b0;
         s.clk_oe       <= 1'b0;                                          // [RULE3]
         s.fs_out       <= 1'b0;
         s.fs_oe        <= 1'b0;                                          // [RULE9]
         s.underrun     <= 1'b0;
         s.rx_tog_prev  <= 1'b0;
         s.rx_data      <= WORD_RESET;
         s.rx_valid     <= 1'b0;
         s.clk_level    <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   // Receive clock domain
   always_comb begin
      next_r         = r;
      next_r.fs_prev = receive_frame_sync;
      if (!r.busy) begin
         if (r.fs_prev && !receive_frame_sync) begin
            next_r.busy  = 1'b1;                                          // [RULE7]
            next_r.count = WORD_COUNT;                                    // [RULE11]
         end
      end else begin
         next_r.shreg = {r.shreg[WORD_BITS-2:0], serial_receive_pin};     // [RULE7]
         next_r.count = r.count - 5'h01;
         if (r.count == 5'h01) begin
            next_r.busy   = 1'b0;                                         // [RULE11]
            next_r.hold   = {r.shreg[WORD_BITS-2:0], serial_receive_pin};
            next_r.toggle = !r.toggle;
         end
      end
   end

   always_ff @(posedge receive_clock_pin or negedge nrst) begin
      if (!nrst) begin
         r.fs_prev <= FS_RESET;
         r.busy    <= 1'b0;
         r.count   <= COUNT_RESET;
         r.shreg   <= WORD_RESET;
         r.hold    <= WORD_RESET;
         r.toggle  <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   assign transmit_clock_out      = s.clk_out;
   assign transmit_clock_oe       = s.clk_oe;
   assign transmit_frame_sync_out = s.fs_out;
   assign transmit_frame_sync_oe  = s.fs_oe;
   assign serial_transmit_pin     = s.dx;
   assign serial_transmit_oe      = s.dx_oe;
   assign rx_data                 = s.rx_data;
   assign rx_valid                = s.rx_valid;
   assign receive_clock_level_bit = s.clk_level;
   assign tx_underrun             = s.underrun;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence frame_start_seq;
      s.phase == TX_IDLE && !frame_sync_output_select && fs_fall;
   endsequence

   sequence word_loaded_seq;
      s.phase == TX_SHIFT && s.count == WORD_COUNT;
   endsequence

   a_ext_clock_input: assert property (!clock_source_select |=> !transmit_clock_oe) // [RULE1]
      else $error("transmit clock driven in external mode");
   a_ext_clock_timing: assert property ((!clock_source_select && s.phase == TX_SHIFT
      && !tx_rise) |=> $stable(serial_transmit_pin)) // [RULE1]
      else $error("transmit data moved without an external clock edge");
   a_int_clock_half: assert property ((transmit_clock_oe && $past(transmit_clock_oe))
      |-> transmit_clock_out != $past(transmit_clock_out)) // [RULE2]
      else $error("internal transmit clock not at half rate");
   a_clock_reset_input: assert property ($rose(nrst) |-> !transmit_clock_oe) // [RULE3]
      else $error("transmit clock driven after reset");
   a_shift_msb_first: assert property ((s.phase == TX_SHIFT && tx_rise)
      |=> serial_transmit_pin == $past(s.shreg[WORD_BITS-1])) // [RULE4]
      else $error("transmit bit not taken from register top");
   a_level_status: assert property (level_s |=> receive_clock_level_bit) // [RULE6]
      else $error("receive clock level status wrong");
   a_rx_frame_start: assert property (@(posedge receive_clock_pin) disable iff (!nrst)
      (!r.busy && r.fs_prev && !receive_frame_sync) |=> r.busy) // [RULE7]
      else $error("receive did not start on frame sync fall");
   a_tx_frame_start: assert property (frame_start_seq |=> word_loaded_seq) // [RULE8]
      else $error("transmit did not start on frame sync fall");
   a_fs_output_sel: assert property (!frame_sync_output_select |=> !transmit_frame_sync_oe) // [RULE9]
      else $error("frame sync driven while selected as input");
   a_off_floats: assert property (off_s |=> (!serial_transmit_oe && !transmit_clock_oe
      && !transmit_frame_sync_oe)) // [RULE10]
      else $error("output driven in output-disable condition");
   a_one_word_only: assert property ((s.phase == TX_SHIFT && s.count == 5'h01 && tx_rise)
      |=> s.phase == TX_IDLE) // [RULE11]
      else $error("transmit did not stop after one word");

endmodule
`default_nettype wire

// File: test/ssp_partner.sv
// Behavioural codec model on the far side of the serial port
`timescale 1ns/10ps
`default_nettype none
module ssp_partner
   import ssp_pkg::*;
(
   input  wire logic                 rx_req,
   input  wire logic [WORD_BITS-1:0] rx_word,
   input  wire logic                 idle_level,
   input  wire logic                 tx_req,
   input  wire logic                 tclk_wire,
   input  wire logic                 tfs_wire,
   input  wire logic                 dx,
   output var  logic                 receive_clock_pin,
   output var  logic                 serial_receive_pin,
   output var  logic                 receive_frame_sync,
   output var  logic                 tclk_drive,
   output var  logic                 tfs_drive,
   output var  logic [WORD_BITS-1:0] tx_seen,
   output var  int                   tx_cnt
);
   logic rclk;
   logic rx_busy;
   // Receive clock stands still outside frames
   assign receive_clock_pin = rx_busy ? rclk : idle_level;
   initial begin
      rclk = 1'b0;
      rx_busy = 1'b0;
      receive_frame_sync = 1'b1;
      serial_receive_pin = 1'b0;
      tclk_drive = 1'b0;
      tfs_drive = 1'b1;
      tx_seen = 16'h0000;
      tx_cnt = 0;
   end
   // One receive word, clock running through the whole frame, 32 ns period
   always @(rx_req) if ($time > 0) begin
      rx_busy = 1'b1;
      #16 rclk = 1'b1;
      #16 rclk = 1'b0;
      receive_frame_sync = 1'b0;
      #16 rclk = 1'b1;
      #16 rclk = 1'b0;
      receive_frame_sync = 1'b1;
      for (int i = WORD_BITS - 1; i >= 0; i--) begin
         serial_receive_pin = rx_word[i];
         #16 rclk = 1'b1;
         #16 rclk = 1'b0;
      end
      serial_receive_pin = ~rx_word[0];
      rx_busy = 1'b0;
   end
   // External transmit frame; slow clock leaves room for the input synchroniser
   always @(tx_req) if ($time > 0) begin
      #5 tfs_drive = 1'b0;
      #50;
      repeat (WORD_BITS) begin
         tclk_drive = 1'b1;
         #50 tclk_drive = 1'b0;
         #50;
      end
      tfs_drive = 1'b1;
   end
   // Sample transmit data on falling transmit clock after the frame sync fall
   always @(negedge tfs_wire) begin
      // Skip a clock rise that shares the time step of the frame sync fall
      #1;
      @(posedge tclk_wire);
      repeat (WORD_BITS) begin
         @(negedge tclk_wire);
         tx_seen = {tx_seen[WORD_BITS-2:0], dx};
      end
      tx_cnt++;
   end
endmodule
`default_nettype wire

// File: test/sync_serial_port_pins_tb.sv
// Self-checking testbench for the synchronous serial port pins
`timescale 1ns/10ps
`default_nettype none
module sync_serial_port_pins_tb
   import ssp_pkg::*;
;
   logic mclk, nrst, clock_source_select, frame_sync_output_select, tx_valid;
   logic test_reset_pin, emulator_pin_zero, emulator_pin_one_disable;
   logic rx_req, tx_req, idle_level, under_seen, tx_ready, rx_valid, tx_underrun;
   logic receive_clock_pin, serial_receive_pin, receive_frame_sync, tclk_drive, tfs_drive;
   logic transmit_clock_out, transmit_clock_oe, transmit_frame_sync_out;
   logic transmit_frame_sync_oe, serial_transmit_pin, serial_transmit_oe;
   logic receive_clock_level_bit;
   logic [WORD_BITS-1:0] tx_data, rx_word, tx_seen, rx_got, rx_data;
   int tx_cnt, rx_cnt, miscompares, checks_done;
   wire logic tclk_wire = transmit_clock_oe ? transmit_clock_out : tclk_drive;
   wire logic tfs_wire = transmit_frame_sync_oe ? transmit_frame_sync_out : tfs_drive;

   sync_serial_port u_dut (.mclk, .nrst, .receive_clock_pin, .serial_receive_pin,
      .receive_frame_sync, .transmit_clock_in(tclk_wire), .transmit_clock_out,
      .transmit_clock_oe, .transmit_frame_sync_in(tfs_wire), .transmit_frame_sync_out,
      .transmit_frame_sync_oe, .serial_transmit_pin, .serial_transmit_oe, .test_reset_pin,
      .emulator_pin_zero, .emulator_pin_one_disable, .clock_source_select,
      .frame_sync_output_select, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid,
      .receive_clock_level_bit, .tx_underrun);
   ssp_partner u_partner (.rx_req, .rx_word, .idle_level, .tx_req, .tclk_wire, .tfs_wire,
      .dx(serial_transmit_pin), .receive_clock_pin, .serial_receive_pin,
      .receive_frame_sync, .tclk_drive, .tfs_drive, .tx_seen, .tx_cnt);

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Catch one-cycle pulses
   always @(posedge mclk) begin
      if (rx_valid === 1'b1) begin
         rx_got <= rx_data;
         rx_cnt <= rx_cnt + 1;
      end
      if (tx_underrun === 1'b1) under_seen <= 1'b1;
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic push(input logic [WORD_BITS-1:0] w);
      @(posedge mclk);
      tx_data <= w;
      tx_valid <= 1'b1;
      for (int k = 0; k < 100; k++) begin
         @(posedge mclk);
         if (tx_ready === 1'b1) break;
      end
      tx_valid <= 1'b0;
   endtask
   task automatic wait_n(input logic use_rx, input int n, input string what);
      for (int k = 0; k < 3000 && (use_rx ? rx_cnt : tx_cnt) < n; k++) @(posedge mclk);
      check(what, 16'(use_rx ? rx_cnt : tx_cnt), 16'(n));
   endtask

   task automatic t_level;
      @(posedge mclk);
      idle_level <= 1'b1;
      repeat (6) @(negedge mclk);
      check("clock level high", receive_clock_level_bit, 1'b1);
      @(posedge mclk);
      idle_level <= 1'b0;
      repeat (6) @(negedge mclk);
      check("clock level low", receive_clock_level_bit, 1'b0);
      $display("test level done");
   endtask
   task automatic t_ext_tx;
      logic [WORD_BITS-1:0] exp [3] = '{16'hA5C3, 16'h0F0F, 16'h0000};
      push(16'hA5C3);
      push(16'h0F0F);
      repeat (2) @(negedge mclk);
      check("buffer full", tx_ready, 1'b0);
      @(posedge mclk);
      tx_data <= 16'hFFFF;
      tx_valid <= 1'b1;
      @(posedge mclk);
      tx_valid <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         repeat (20) @(posedge mclk);
         check("underrun before", under_seen, 1'b0);
         tx_req <= ~tx_req;
         wait_n(1'b0, i + 1, "ext frames");
         check("ext word", tx_seen, exp[i]);
         check("clock pin input", transmit_clock_oe, 1'b0);
      end
      repeat (4) @(negedge mclk);
      check("underrun flag", under_seen, 1'b1);
      check("buffer free", tx_ready, 1'b1);
      $display("test ext_tx done");
   endtask
   task automatic t_rx;
      logic [WORD_BITS-1:0] words [2] = '{16'h8421, 16'h7FFE};
      for (int i = 0; i < 2; i++) begin
         @(posedge mclk);
         rx_word <= words[i];
         rx_req <= ~rx_req;
         wait_n(1'b1, i + 1, "rx words");
         repeat (200) @(posedge mclk);
         check("rx word", rx_got, words[i]);
         check("rx count", 16'(rx_cnt), 16'(i + 1));
      end
      $display("test rx done");
   endtask
   task automatic t_int;
      logic v;
      int base;
      @(posedge mclk);
      clock_source_select <= 1'b1;
      frame_sync_output_select <= 1'b1;
      repeat (60) @(negedge mclk);
      check("clock enable", transmit_clock_oe, 1'b1);
      check("fs enable", transmit_frame_sync_oe, 1'b1);
      v = transmit_clock_out;
      @(negedge mclk);
      check("clock toggle", transmit_clock_out, !v);
      @(negedge mclk);
      check("clock toggle", transmit_clock_out, v);
      base = tx_cnt;
      push(16'h1234);
      wait_n(1'b0, base + 1, "int frames");
      check("int word", tx_seen, 16'h1234);
      $display("test int_tx done");
   endtask
   task automatic t_off;
      logic [2:0] pins [3] = '{3'b010, 3'b000, 3'b011};
      logic [2:0] oes [3] = '{3'b000, 3'b111, 3'b111};
      for (int i = 0; i < 3; i++) begin
         @(posedge mclk);
         {test_reset_pin, emulator_pin_zero, emulator_pin_one_disable} <= pins[i];
         repeat (6) @(negedge mclk);
         check("enables", {transmit_clock_oe, transmit_frame_sync_oe, serial_transmit_oe},
               oes[i]);
      end
      $display("test off done");
   endtask

   initial begin
      #200us;
      miscompares++;
      test_done();
   end
   initial begin
      {nrst, clock_source_select, frame_sync_output_select, tx_valid, test_reset_pin} = '0;
      {emulator_pin_zero, emulator_pin_one_disable, rx_req, tx_req} = 4'b1100;
      {idle_level, under_seen} = '0;
      tx_data = 16'h0000;
      rx_word = 16'h0000;
      repeat (5) @(posedge mclk);
      nrst <= 1'b1;
      repeat (4) @(negedge mclk);
      check("reset clock enable", transmit_clock_oe, 1'b0);
      check("reset fs enable", transmit_frame_sync_oe, 1'b0);
      t_level();
      t_ext_tx();
      t_rx();
      t_int();
      t_off();
      test_done();
   end
endmodule
`default_nettype wire
